//--- core/tpdc_top.sv
// thermal printhead dot controller: column fetch, serial shift, dot_pulse_a pulse
`default_nettype none
module tpdc_top
  import tpdc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic COL_VALID,
  output logic COL_READY,
  input wire logic [WORD_W-1:0] COL_DATA,
  input wire logic COL_LAST,
  input wire logic [TEMP_W-1:0] HEAD_TEMP,
  input wire logic [CNT_W-1:0] DOT_PULSE_A_BASE,
  output logic HEAD_SDATA,
  output logic HEAD_SCLK,
  output logic HEAD_LATCH_N,
  output logic DOT_PULSE_A,
  output logic HEAD_OVERTEMP_FLAG,
  output logic COL_SKIPPED
);
  // ----------------------------------------------------------------
  // input buffering
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(COL_CYCLES - 1);
  localparam logic [1:0] DIV_LAST = 2'(SHIFT_DIV - 1);
  localparam logic [WCNT_W-1:0] WORDS_LAST = WCNT_W'(WORDS_PER_COL - 1);
  localparam logic [3:0] BIT_LAST = 4'(WORD_W - 1);
  tpdc_word_t in_word;
  tpdc_word_t out_word;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [ENTRY_W-1:0] f_out_data;
  logic [DOTS-1:0] col_q;
  logic [WCNT_W-1:0] wcnt_q;
  logic [3:0] bit_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] dot_pulse_a_q;
  logic [CNT_W-1:0] dot_pulse_a_len;
  logic [CNT_W-1:0] derate;
  logic [1:0] div_q;
  logic col_start;
  logic shift_tick;
  tpdc_state_t st_q;
  assign in_word.dots = COL_DATA;
  assign in_word.last = COL_LAST;
  assign out_word = tpdc_word_t'(f_out_data);
  tpdc_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(COL_VALID && COL_READY), // only handshaken words enter the fifo
    .in_ready(f_in_ready),
    .in_data(in_word),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );
  // ready registered; low for a cycle after each take so a stale full flag never admits a word
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      COL_READY <= 1'b0;
    end else begin
      COL_READY <= f_in_ready && !(COL_VALID && COL_READY);
    end
  end
  // ----------------------------------------------------------------
  // period timer and shift clock divider
  // ----------------------------------------------------------------
  // one column period
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      period_q <= ZERO_CNT;
    end else begin
      period_q <= (period_q == PERIOD_LAST) ? ZERO_CNT : period_q + ONE_CNT;
    end
  end
  assign col_start = (period_q == PERIOD_LAST);
  // shift clock divider enable
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (st_q == ST_SHIFT) ? div_q + 2'h1 : 2'h0;
    end
  end
  assign shift_tick = (div_q == DIV_LAST);
  // ----------------------------------------------------------------
  // temperature handling
  // ----------------------------------------------------------------
  // hysteresis flag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HEAD_OVERTEMP_FLAG <= 1'b0;
    end else if (HEAD_TEMP > TEMP_HI) begin
      HEAD_OVERTEMP_FLAG <= 1'b1;
    end else if (HEAD_TEMP < TEMP_LO) begin
      HEAD_OVERTEMP_FLAG <= 1'b0;
    end
  end
  // linear derating, clamped to a floor
  assign derate = CNT_W'(HEAD_TEMP) * DOT_PULSE_A_STEP;
  always_comb begin
    dot_pulse_a_len = (DOT_PULSE_A_BASE > derate + DOT_PULSE_A_MIN) ? DOT_PULSE_A_BASE - derate : DOT_PULSE_A_MIN;
    if (dot_pulse_a_len > DOT_PULSE_A_MAX_DEF) begin
      dot_pulse_a_len = DOT_PULSE_A_MAX_DEF;
    end
  end
  // ----------------------------------------------------------------
  // column sequencer
  // ----------------------------------------------------------------
  assign f_out_ready = (st_q == ST_LOAD);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= ST_LOAD;
      wcnt_q <= '0;
      bit_q <= 4'h0;
      dot_pulse_a_q <= ZERO_CNT;
      COL_SKIPPED <= 1'b0;
    end else begin
      COL_SKIPPED <= 1'b0;
      case (st_q)
        ST_WAIT: begin
          // whole column held; shifting starts at the period boundary
          if (col_start) begin
            st_q <= ST_SHIFT;
            wcnt_q <= '0;
            bit_q <= 4'h0;
          end
        end
        ST_LOAD: begin
          // gather the column whole, the fifo is far shorter than a column
          if (f_out_valid) begin
            wcnt_q <= wcnt_q + 1'b1;
            if (out_word.last || wcnt_q == WORDS_LAST) begin
              st_q <= ST_WAIT;
              wcnt_q <= '0;
            end
          end
          if (col_start) begin
            COL_SKIPPED <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (shift_tick) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == BIT_LAST) begin
              wcnt_q <= wcnt_q + 1'b1;
              if (wcnt_q == WORDS_LAST) begin
                st_q <= ST_LATCH;
              end
            end
          end
        end
        ST_LATCH: begin
          dot_pulse_a_q <= dot_pulse_a_len;
          st_q <= HEAD_OVERTEMP_FLAG ? ST_IDLE : ST_DOT_PULSE_A;
        end
        ST_DOT_PULSE_A: begin
          if (dot_pulse_a_q == ZERO_CNT || HEAD_OVERTEMP_FLAG || period_q > PERIOD_LAST - DOT_PULSE_A_GUARD) begin
            st_q <= ST_IDLE;
          end else begin
            dot_pulse_a_q <= dot_pulse_a_q - ONE_CNT;
          end
        end
        ST_IDLE: begin
          // word count restarts for the next column
          st_q <= ST_LOAD;
          wcnt_q <= '0;
        end
        default: begin
          st_q <= ST_LOAD;
        end
      endcase
    end
  end
  // column store, shifted out msb first
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      col_q <= '0;
    end else if (st_q == ST_LOAD && f_out_valid) begin
      col_q <= {col_q[DOTS-WORD_W-1:0], out_word.dots};
    end else if (st_q == ST_SHIFT && shift_tick) begin
      col_q <= {col_q[DOTS-2:0], 1'b0};
    end
  end
  // ----------------------------------------------------------------
  // head pins
  // ----------------------------------------------------------------
  // data set up half a shift clock before rising edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HEAD_SDATA <= 1'b0;
      HEAD_SCLK <= 1'b0;
      HEAD_LATCH_N <= 1'b1;
    end else begin
      HEAD_SDATA <= (st_q == ST_SHIFT) ? col_q[DOTS-1] : 1'b0;
      HEAD_SCLK <= (st_q == ST_SHIFT) && div_q[1];
      HEAD_LATCH_N <= !(st_q == ST_LATCH);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DOT_PULSE_A <= 1'b0;
    end else begin
      DOT_PULSE_A <= (st_q == ST_DOT_PULSE_A) && (dot_pulse_a_q != ZERO_CNT) && !HEAD_OVERTEMP_FLAG;
    end
  end
endmodule : tpdc_top
`default_nettype wire

//--- core/tpdc_pkg.sv
// package of constants and types for the thermal printhead dot controller
`default_nettype none
package tpdc_pkg;
  // ----------------------------------------------------------------
  // head geometry
  // ----------------------------------------------------------------
  localparam int HEAD_LEN_MM = 216;
  localparam int LINE_MM = 200;
  localparam int DOTS_PER_MM = 8;
  localparam int X_DOTS_PER_MM_MAX = 40;
  localparam int DOTS = LINE_MM * DOTS_PER_MM;
  localparam int WORD_W = 16;
  localparam int WORDS_PER_COL = DOTS / WORD_W;
  localparam int WCNT_W = $clog2(WORDS_PER_COL + 1);
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = $clog2(FIFO_DEPTH);
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int COL_RATE_HZ = 1000;
  localparam int COL_CYCLES = CLK_HZ / COL_RATE_HZ;
  localparam int SHIFT_DIV = 4;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] DOT_PULSE_A_MAX_DEF = 16'h7530;
  localparam logic [CNT_W-1:0] DOT_PULSE_A_MIN = 16'h03E8;
  localparam logic [CNT_W-1:0] DOT_PULSE_A_GUARD = 16'h0FA0;
  // ----------------------------------------------------------------
  // temperature, code in deg C
  // ----------------------------------------------------------------
  localparam int TEMP_W = 8;
  localparam logic [TEMP_W-1:0] TEMP_HI = 8'h37;
  localparam logic [TEMP_W-1:0] TEMP_LO = 8'h32;
  localparam logic [CNT_W-1:0] DOT_PULSE_A_STEP = 16'h00C8;
  localparam logic [CNT_W-1:0] ZERO_CNT = 16'h0000;
  localparam logic [CNT_W-1:0] ONE_CNT = 16'h0001;
  typedef struct packed {
    logic [WORD_W-1:0] dots;
    logic last;
  } tpdc_word_t;
  localparam int ENTRY_W = $bits(tpdc_word_t);
  typedef enum {ST_WAIT, ST_LOAD, ST_SHIFT, ST_LATCH, ST_DOT_PULSE_A, ST_IDLE} tpdc_state_t;
endpackage : tpdc_pkg
`default_nettype wire

//--- core/tpdc_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`default_nettype none
module tpdc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  // full when pointers differ only in wrap bit
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : tpdc_fifo
`default_nettype wire

//--- testbench/tpdc_chk_sva.sv
// checker for the thermal printhead dot controller top ports
`default_nettype none
module tpdc_chk
  import tpdc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic COL_VALID,
  input wire logic COL_READY,
  input wire logic [TEMP_W-1:0] HEAD_TEMP,
  input wire logic HEAD_LATCH_N,
  input wire logic DOT_PULSE_A,
  input wire logic HEAD_OVERTEMP_FLAG,
  input wire logic COL_SKIPPED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] since_q;
  logic [CNT_W-1:0] width_q;
  // cycles since the last latch, saturating
  always_ff @(posedge CLK) begin
    if (!RST_N) since_q <= 4'hF;
    else if (!HEAD_LATCH_N) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  // length of the running dot_pulse_a pulse
  always_ff @(posedge CLK) begin
    if (!RST_N || !DOT_PULSE_A) width_q <= ZERO_CNT;
    else width_q <= width_q + ONE_CNT;
  end
  sequence hot2; (HEAD_TEMP > TEMP_HI) [*2]; endsequence
  sequence cool2; (HEAD_TEMP < TEMP_LO) [*2]; endsequence
  flag_set_a: assert property (hot2 |-> HEAD_OVERTEMP_FLAG)
    else $error("flag not set when hot");
  flag_clear_a: assert property (cool2 |-> !HEAD_OVERTEMP_FLAG)
    else $error("flag not cleared when cool");
  flag_hold_a: assert property (HEAD_OVERTEMP_FLAG && HEAD_TEMP >= TEMP_LO
    |=> HEAD_OVERTEMP_FLAG) else $error("flag dropped early");
  hot_no_dot_pulse_a_a: assert property (HEAD_OVERTEMP_FLAG [*2] |-> !DOT_PULSE_A)
    else $error("heating while overtemp");
  latch_short_a: assert property (!HEAD_LATCH_N |=> HEAD_LATCH_N)
    else $error("latch longer than one cycle");
  dot_pulse_a_after_latch_a: assert property ($rose(DOT_PULSE_A) |-> since_q <= 4'h3)
    else $error("dot_pulse_a not right after latch");
  latch_cold_a: assert property (!HEAD_LATCH_N |-> !DOT_PULSE_A)
    else $error("dot_pulse_a across a latch");
  dot_pulse_a_max_a: assert property (width_q <= DOT_PULSE_A_MAX_DEF)
    else $error("dot_pulse_a pulse too long");
  ready_gap_a: assert property (COL_VALID && COL_READY |=> !COL_READY)
    else $error("ready not dropped after take");
  skip_cold_a: assert property (COL_SKIPPED |=> !DOT_PULSE_A [*8])
    else $error("dot_pulse_a in skipped period");
endmodule : tpdc_chk
bind tpdc_top tpdc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .COL_VALID(COL_VALID),
  .COL_READY(COL_READY), .HEAD_TEMP(HEAD_TEMP), .HEAD_LATCH_N(HEAD_LATCH_N),
  .DOT_PULSE_A(DOT_PULSE_A), .HEAD_OVERTEMP_FLAG(HEAD_OVERTEMP_FLAG),
  .COL_SKIPPED(COL_SKIPPED));
`default_nettype wire

//--- testbench/tpdc_head_model.sv
// model of the printhead shift register, latch and heater
`default_nettype none
module tpdc_head_model (
  input wire logic clk,
  input wire logic sdata,
  input wire logic sclk,
  input wire logic latch_n,
  input wire logic pulse,
  output logic [15:0] first_bits,
  output logic [15:0] held_bits,
  output logic [15:0] dot_pulse_a_cycles
);
  logic sclk_p = 1'b0;
  logic [15:0] nbits = 16'h0000;
  initial first_bits = 16'h0000;
  initial held_bits = 16'h0000;
  initial dot_pulse_a_cycles = 16'h0000;
  always @(posedge clk) begin
    sclk_p <= sclk;
    if (sclk && !sclk_p) begin
      if (nbits < 16'h0010) first_bits <= {first_bits[14:0], sdata};
      nbits <= nbits + 16'h0001;
    end
    if (!latch_n) begin
      held_bits <= nbits;
      nbits <= 16'h0000;
    end
    if (pulse) dot_pulse_a_cycles <= dot_pulse_a_cycles + 16'h0001;
  end
endmodule : tpdc_head_model
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the printhead dot controller
`default_nettype none
module testbench
  import tpdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, col_valid = 1'b0, col_last = 1'b0;
  logic [WORD_W-1:0] col_data = 16'h0000;
  logic [TEMP_W-1:0] head_temp = 8'h19;
  logic [CNT_W-1:0] dot_pulse_a_base = 16'h2710;
  logic col_ready, sdata, sclk, latch_n, pulse, flag, skipped;
  logic [15:0] first_bits, held_bits, dot_pulse_a_cycles;
  int err_count = 0, n_checks = 0, cyc = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  tpdc_top dut (.CLK(clk), .RST_N(rst_n), .COL_VALID(col_valid), .COL_READY(col_ready),
    .COL_DATA(col_data), .COL_LAST(col_last), .HEAD_TEMP(head_temp), .DOT_PULSE_A_BASE(dot_pulse_a_base),
    .HEAD_SDATA(sdata), .HEAD_SCLK(sclk), .HEAD_LATCH_N(latch_n), .DOT_PULSE_A(pulse),
    .HEAD_OVERTEMP_FLAG(flag), .COL_SKIPPED(skipped));
  tpdc_head_model head (.clk(clk), .sdata(sdata), .sclk(sclk), .latch_n(latch_n),
    .pulse(pulse), .first_bits(first_bits), .held_bits(held_bits),
    .dot_pulse_a_cycles(dot_pulse_a_cycles));
  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk
  task give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // one full column, held until ready, last word marked
  task send_col;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      col_valid = 1'b1;
      col_data = (i == 0) ? 16'hA5C3 : 16'(i);
      col_last = (i == 99);
      while (col_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    col_valid = 1'b0;
    col_last = 1'b0;
  endtask : send_col
  task t_column_dot_pulse_a;
    logic [CNT_W-1:0] exp_len;
    exp_len = dot_pulse_a_base - 16'(head_temp) * DOT_PULSE_A_STEP;
    send_col();
    while (latch_n !== 1'b0) @(negedge clk);
    while (pulse !== 1'b1) @(negedge clk);
    while (pulse === 1'b1) @(negedge clk);
    chk(held_bits === 16'(DOTS), "dot count");
    chk(first_bits === 16'hA5C3, "first dots order");
    chk(dot_pulse_a_cycles === exp_len, "dot_pulse_a width");
    $display("done column_dot_pulse_a");
  endtask : t_column_dot_pulse_a
  task t_skip;
    logic [15:0] h0;
    h0 = dot_pulse_a_cycles;
    for (int i = 0; i < COL_CYCLES && skipped !== 1'b1; i++) @(negedge clk);
    chk(skipped === 1'b1, "no skip pulse in empty period");
    repeat (20) @(negedge clk);
    chk(dot_pulse_a_cycles === h0, "dot_pulse_a in empty period");
    $display("done skip");
  endtask : t_skip
  task t_overtemp;
    logic [7:0] tt [4];
    logic ex [4];
    tt = '{8'h37, 8'h3C, 8'h34, 8'h31};
    ex = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      head_temp = tt[i];
      repeat (3) @(negedge clk);
      chk(flag === ex[i], "overtemp flag");
    end
    $display("done overtemp");
  endtask : t_overtemp
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 85000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_column_dot_pulse_a();
    t_skip();
    t_overtemp();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
